// ===== design/io_cell_input_tristate_regs.sv
`timescale 1ns/1ps
// Behaviour
// R01: Pad feeds comb path, SDR stage, delay line.
// R02: Delayed signal selectable for comb, gearbox, SDR.
// R03: First input latch captures on high-speed edge.
// R04: Second element register or latch, low-speed clock.
// R05: Both input elements use shared clock enable.
// R06: Set/reset value, async/sync local reset, overrides enable.
// R07: Input elements reset by input-side local reset.
// R08: Global set/reset maskable per cell.
// R09: 144-tap delay, from configuration or automatic.
// R10: Tap setting from configuration or calibration bus.
// R11: Aligner searches clean point, then tracks drift.
// R12: Aligner moves only on observed data transitions.
// R13: Window size selectable; track or hold delay.
// R14: Aligner serves single- and double-rate capture.
// R15: Gearbox does x2, paired cells do x4.
// R16: Aligner present only in selected cells.
// R17: Gearbox hands data to low-speed domain.
// R18: Tristate: one SDR register, three serial registers.
// R19: Tristate source: bypass, SDR, serial, open-drain.
// R20: Tristate SDR register with output-side resets.
// R21: Tristate serializer turns parallel word into stream.
// R22: Termination off while driving, on while receiving.
// R23: Low-speed clock is high-speed divided by gearing.
module io_cell_input_tristate_regs
#(
   parameter bit HAS_ALIGNER = 1'b1,
   parameter int GEAR = io_cell_pkg::GEAR_MAX
)
(
   input wire logic clock_in,
   input wire logic arst_n_in,
   input wire logic pad_buffer_input_in,
   input wire logic comb_sel_delayed_in,
   input wire logic sdr_sel_delayed_in,
   input wire logic gear_sel_delayed_in,
   input wire logic tap_from_bus_in,
   input wire logic [io_cell_pkg::TAP_W-1:0] tap_config_in,
   input wire logic [io_cell_pkg::TAP_W-1:0] calibration_bus_in,
   input wire logic aligner_enable_in,
   input wire logic aligner_hold_in,
   input wire logic [io_cell_pkg::WIN_W-1:0] window_size_in,
   input wire logic gear_x4_in,
   input wire logic input_clock_enable_in,
   input wire logic input_side_local_reset_in,
   input wire logic output_side_local_reset_in,
   input wire logic global_set_reset_in,
   input wire logic gsr_enable_input_in,
   input wire logic gsr_enable_tristate_in,
   input wire logic input_set_mode_in,
   input wire logic tristate_set_mode_in,
   input wire logic lsr_async_in,
   input wire logic second_is_latch_in,
   input wire logic tristate_bypass_in,
   input wire logic tristate_sdr_in,
   input wire logic [GEAR-1:0] tristate_word_in,
   input wire logic [1:0] tristate_sel_in,
   input wire logic pad_data_in,
   input wire logic termination_mode_in,
   output logic comb_input_to_fabric_out,
   output logic input_clock_to_fabric_out,
   output logic registered_input_to_fabric_out,
   output logic [GEAR-1:0] gearbox_word_out,
   output logic gearbox_valid_out,
   output logic [io_cell_pkg::TAP_W-1:0] delay_tap_out,
   output logic aligner_locked_out,
   output logic pad_tristate_control_out,
   output logic termination_on_out
);
   logic rst_meta_q;
   logic rst_n_q;
   logic [io_cell_pkg::DELAY_TAPS-1:0] chain_q;
   logic [io_cell_pkg::TAP_W-1:0] tap_q;
   logic [io_cell_pkg::TAP_W-1:0] tap_d;
   logic locked_q;
   logic delayed;
   logic comb_src;
   logic sdr_src;
   logic gear_src;
   logic [io_cell_pkg::GEAR_CNT_W-1:0] phase_q;
   logic slow_tick;
   logic slow_level;
   logic first_q;
   logic second_q;
   logic [GEAR-1:0] gear_shift_q;
   logic [GEAR-1:0] ts_load_q;
   logic [GEAR-1:0] ts_shift_q;
   logic ts_serial_q;
   logic ts_sdr_q;
   logic ts_d;
   logic in_init;
   logic ts_init;
   logic in_lsr_now;
   logic ts_lsr_now;

   // Picks the forced level of an element; local reset beats global.
   function automatic logic forced_level(input logic set_mode);
      return set_mode ? io_cell_pkg::INIT_SET : io_cell_pkg::INIT_RESET;
   endfunction

   // Clamps a tap index into the chain.
   function automatic logic [io_cell_pkg::TAP_W-1:0] clamp_tap(
      input logic [io_cell_pkg::TAP_W-1:0] t);
      return (t > io_cell_pkg::TAP_MAX) ? io_cell_pkg::TAP_MAX : t;
   endfunction

   // Reset release through two flip-flops; only the first sees a constant.
   always_ff @(posedge clock_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // Delay chain: each tap holds the pad one cycle older than the one before.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
         chain_q <= '0;
      else
         chain_q <= {chain_q[io_cell_pkg::DELAY_TAPS-2:0], pad_buffer_input_in}; // R09 R01
   end

   assign delayed = chain_q[tap_q];
   assign comb_src = comb_sel_delayed_in ? delayed : pad_buffer_input_in; // R01 R02
   assign sdr_src = sdr_sel_delayed_in ? delayed : pad_buffer_input_in; // R02
   assign gear_src = gear_sel_delayed_in ? delayed : pad_buffer_input_in; // R02

   // Tap choice. The aligner compares the samples one window either side of
   // the current tap; an edge on one side pushes the tap the other way, so it
   // moves only on real transitions and needs no training pattern.
   always_comb
   begin
      logic [io_cell_pkg::TAP_W-1:0] win;
      logic [io_cell_pkg::TAP_W-1:0] lo;
      logic [io_cell_pkg::TAP_W-1:0] hi;
      logic edge_lo;
      logic edge_hi;
      win = {{(io_cell_pkg::TAP_W-io_cell_pkg::WIN_W){1'b0}},
             (window_size_in == '0) ? io_cell_pkg::WIN_MIN : window_size_in}; // R13
      lo = (tap_q > win) ? tap_q - win : '0;
      hi = clamp_tap(tap_q + win);
      edge_lo = chain_q[lo] != chain_q[tap_q];
      edge_hi = chain_q[hi] != chain_q[tap_q];
      if (HAS_ALIGNER && aligner_enable_in) // R16
      begin
         if (aligner_hold_in)
            tap_d = tap_q; // R13
         else if (edge_lo && !edge_hi && tap_q < io_cell_pkg::TAP_MAX)
            tap_d = tap_q + 8'h01; // R11 R12
         else if (edge_hi && !edge_lo && tap_q != '0)
            tap_d = tap_q - 8'h01; // R11 R12
         else
            tap_d = tap_q;
      end
      else
         tap_d = clamp_tap(tap_from_bus_in ? calibration_bus_in : tap_config_in); // R10 R09
   end

   // Tap register; the aligner reports lock while it keeps its place.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         tap_q <= io_cell_pkg::TAP_RESET;
         locked_q <= 1'b0;
      end
      else
      begin
         tap_q <= tap_d;
         locked_q <= HAS_ALIGNER && aligner_enable_in && (tap_d == tap_q); // R11
      end
   end

   // Low-speed phase: the fabric clock is modelled as every second or fourth
   // high-speed edge, so the hand-off is deterministic by construction.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
         phase_q <= '0;
      else if (slow_tick)
         phase_q <= '0; // R23
      else
         phase_q <= phase_q + 2'h1;
   end

   assign slow_tick = phase_q == (gear_x4_in ? io_cell_pkg::GEAR_LAST_X4
                                             : io_cell_pkg::GEAR_LAST_X2);
   assign slow_level = phase_q == '0;
   assign in_init = forced_level(input_set_mode_in);
   assign ts_init = forced_level(tristate_set_mode_in);
   assign in_lsr_now = input_side_local_reset_in && lsr_async_in;
   assign ts_lsr_now = output_side_local_reset_in && lsr_async_in;

   // First input element on the high-speed edge. Its own clock is the fast
   // edge, so a local reset of either kind acts at the next edge and beats
   // the enable; the two kinds only differ for the slow second element.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
         first_q <= io_cell_pkg::INIT_RESET;
      else if (in_lsr_now || input_side_local_reset_in)
         first_q <= in_init; // R06 R07
      else if (global_set_reset_in && gsr_enable_input_in)
         first_q <= in_init; // R08
      else if (input_clock_enable_in)
         first_q <= sdr_src; // R03 R05
   end

   // Second element: captures at the low-speed edge as a register, or stays
   // open for the first high-speed edge of each slow period as a latch.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
         second_q <= io_cell_pkg::INIT_RESET;
      else if (in_lsr_now || (input_side_local_reset_in && slow_tick))
         second_q <= in_init; // R06 R07
      else if (global_set_reset_in && gsr_enable_input_in)
         second_q <= in_init; // R08
      else if (input_clock_enable_in && (second_is_latch_in ? slow_level : slow_tick))
         second_q <= first_q; // R04 R05
   end

   // Input gearbox: shifts one high-speed sample per edge, hands the word
   // over at the slow edge. Cells pair for x4 through the wider word.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         gear_shift_q <= '0;
         gearbox_word_out <= '0;
         gearbox_valid_out <= 1'b0;
      end
      else
      begin
         gear_shift_q <= {gear_shift_q[GEAR-2:0], gear_src}; // R15 R14
         gearbox_valid_out <= slow_tick; // R17
         if (slow_tick)
            gearbox_word_out <= gear_x4_in ? {gear_shift_q[GEAR-2:0], gear_src}
                                           : {{(GEAR-2){1'b0}}, gear_shift_q[0], gear_src};
      end
   end

   // Fabric-facing copies of the pad path, tap and status.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         comb_input_to_fabric_out <= 1'b0;
         input_clock_to_fabric_out <= 1'b0;
         registered_input_to_fabric_out <= 1'b0;
         delay_tap_out <= io_cell_pkg::TAP_RESET;
         aligner_locked_out <= 1'b0;
      end
      else
      begin
         comb_input_to_fabric_out <= comb_src; // R01
         input_clock_to_fabric_out <= comb_src; // R01
         registered_input_to_fabric_out <= second_q; // R04
         delay_tap_out <= tap_q;
         aligner_locked_out <= locked_q;
      end
   end

   // Tristate SDR register, reset from the output side.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
         ts_sdr_q <= io_cell_pkg::INIT_RESET;
      else if (output_side_local_reset_in || ts_lsr_now)
         ts_sdr_q <= ts_init; // R20
      else if (global_set_reset_in && gsr_enable_tristate_in)
         ts_sdr_q <= ts_init; // R20
      else
         ts_sdr_q <= tristate_sdr_in; // R20
   end

   // Three serializer registers: parallel load, shift, and bit out. The word
   // is loaded at the slow edge and shifted out lowest bit (bit 0) first.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         ts_load_q <= '0;
         ts_shift_q <= '0;
         ts_serial_q <= 1'b0;
      end
      else
      begin
         if (slow_tick)
         begin
            ts_load_q <= tristate_word_in; // R18 R21
            ts_shift_q <= ts_load_q; // R21
         end
         else
            ts_shift_q <= {1'b0, ts_shift_q[GEAR-1:1]}; // R21
         ts_serial_q <= ts_shift_q[0]; // R18
      end
   end

   // Tristate source select. In open-drain emulation the pad is released
   // whenever the data is high.
   always_comb
   begin
      unique case (io_cell_pkg::ts_sel_e'(tristate_sel_in))
         io_cell_pkg::TS_BYPASS: ts_d = tristate_bypass_in; // R19
         io_cell_pkg::TS_SDR: ts_d = ts_sdr_q; // R19
         io_cell_pkg::TS_SERIAL: ts_d = ts_serial_q; // R19
         io_cell_pkg::TS_OPEN_DRAIN: ts_d = pad_data_in; // R19
      endcase
   end

   // Termination follows the tristate: on while the pad listens.
   always_ff @(posedge clock_in or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         pad_tristate_control_out <= 1'b1;
         termination_on_out <= 1'b0;
      end
      else
      begin
         pad_tristate_control_out <= ts_d;
         termination_on_out <= termination_mode_in && ts_d; // R22
      end
   end

   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!rst_n_q);

   property p_comb_source;
      ##1 comb_input_to_fabric_out == $past(comb_src);
   endproperty
   a_comb_source: assert property (p_comb_source) else $error("comb path wrong"); // R02
   property p_first_capture;
      input_clock_enable_in && !input_side_local_reset_in && !global_set_reset_in
         |=> first_q == $past(sdr_src);
   endproperty
   a_first_capture: assert property (p_first_capture) else $error("first miss"); // R03
   property p_second_reg;
      slow_tick && !second_is_latch_in && input_clock_enable_in
         && !input_side_local_reset_in && !global_set_reset_in
         |=> ##1 registered_input_to_fabric_out == $past(first_q, 2);
   endproperty
   a_second_reg: assert property (p_second_reg) else $error("second miss"); // R04
   property p_enable_hold;
      !input_clock_enable_in && !input_side_local_reset_in && !global_set_reset_in
         |=> $stable(first_q);
   endproperty
   a_enable_hold: assert property (p_enable_hold) else $error("enable ignored"); // R05
   property p_lsr_wins;
      in_lsr_now |=> first_q == $past(in_init) && second_q == $past(in_init);
   endproperty
   a_lsr_wins: assert property (p_lsr_wins) else $error("local reset lost"); // R06
   property p_gsr_mask;
      global_set_reset_in && !gsr_enable_input_in && !input_side_local_reset_in
         && input_clock_enable_in |=> first_q == $past(sdr_src);
   endproperty
   a_gsr_mask: assert property (p_gsr_mask) else $error("gsr not masked"); // R08
   property p_tap_range;
      tap_q <= io_cell_pkg::TAP_MAX;
   endproperty
   a_tap_range: assert property (p_tap_range) else $error("tap out of range"); // R09
   property p_hold;
      aligner_enable_in && aligner_hold_in |=> $stable(tap_q);
   endproperty
   a_hold: assert property (p_hold) else $error("held tap moved"); // R13
   property p_step;
      ##1 (tap_q == $past(tap_q) + 8'h01 || tap_q + 8'h01 == $past(tap_q)
           || tap_q == $past(tap_q) || !$past(aligner_enable_in));
   endproperty
   a_step: assert property (p_step) else $error("aligner jumped"); // R12
   property p_term;
      termination_on_out |-> pad_tristate_control_out;
   endproperty
   a_term: assert property (p_term) else $error("termination while driving"); // R22
   property p_valid_period;
      gearbox_valid_out && gear_x4_in |=> !gearbox_valid_out;
   endproperty
   a_valid_period: assert property (p_valid_period) else $error("tick too soon"); // R17

   c_locked: cover property (aligner_locked_out && !$past(aligner_locked_out));
   c_x4_word: cover property (gear_x4_in && gearbox_valid_out);
   c_serial_ts: cover property (tristate_sel_in == 2'b10 && $fell(pad_tristate_control_out));
   c_term: cover property (termination_on_out);
endmodule

// ===== design/io_cell_pkg.sv
package io_cell_pkg;
   // Delay chain geometry shared by the tap logic and the aligner.
   localparam int DELAY_TAPS = 144;
   localparam int TAP_W = 8;
   localparam logic [TAP_W-1:0] TAP_MAX = 8'h8f;
   localparam logic [TAP_W-1:0] TAP_RESET = 8'h00;
   // Gearing factors between the high-speed and the low-speed domain.
   localparam int GEAR_MAX = 4;
   localparam int GEAR_CNT_W = 2;
   localparam logic [GEAR_CNT_W-1:0] GEAR_LAST_X2 = 2'h1;
   localparam logic [GEAR_CNT_W-1:0] GEAR_LAST_X4 = 2'h3;
   // Aligner window, in taps; a window of zero is treated as one.
   localparam int WIN_W = 4;
   localparam logic [WIN_W-1:0] WIN_MIN = 4'h1;
   // Reset levels of the storage elements.
   localparam logic INIT_RESET = 1'h0;
   localparam logic INIT_SET = 1'h1;
   // Source of the pad tristate control.
   typedef enum logic [1:0]
   {
      TS_BYPASS = 2'b00,
      TS_SDR = 2'b01,
      TS_SERIAL = 2'b10,
      TS_OPEN_DRAIN = 2'b11
   } ts_sel_e;
endpackage

// ===== tb/pad_partner.sv
`timescale 1ns/1ps
// Behavioural pad buffer: drives the cell's pad input, held or with data edges.
module pad_partner
(
   input wire logic clock_in,
   input wire logic [1:0] mode_in,
   input wire logic level_in,
   output logic pad_out
);
   logic [1:0] count_q;
   // Mode 0 holds a level, mode 1 toggles each edge, mode 2 every third edge.
   // Moves only just after the edge, as a real receiver output would settle.
   always @(posedge clock_in)
   begin
      count_q <= (count_q == 2'h2) ? 2'h0 : count_q + 2'h1;
      if (mode_in == 2'h0)
      begin
         pad_out <= level_in;
      end
      else if (mode_in == 2'h1 || count_q == 2'h2)
      begin
         pad_out <= ~pad_out;
      end
   end
   initial
   begin
      count_q = 2'h0;
      pad_out = 1'h0;
   end
endmodule

// ===== tb/testbench.sv
`timescale 1ns/1ps
// Self-checking bench for the input and tristate cell.
module testbench;
   logic clock_in = 1'h0, arst_n_in = 1'h0, csd = 1'h0, ssd = 1'h0, gsd = 1'h0, tfb = 1'h0;
   logic [7:0] tcfg = 8'h00, cbus = 8'h00, tap_seen, tap_held;
   logic al_en = 1'h0, al_hold = 1'h0, gx4 = 1'h0, ce = 1'h1, input_side_local_reset = 1'h0, output_side_local_reset = 1'h0;
   logic global_set_reset = 1'h0, gen_i = 1'h0, gen_t = 1'h0, iset = 1'h0, tset = 1'h0, lasync = 1'h0;
   logic latch2 = 1'h0, tbyp = 1'h0, tsdr = 1'h0, pdat = 1'h0, term = 1'h0, level = 1'h0;
   logic [3:0] tword = 4'h0, win = 4'h2, gword;
   logic [1:0] tsel = 2'h0, pmode = 2'h0;
   logic pad, comb, ick, regd, gvalid, locked, ts, term_on;
   int miscompares = 0, checks_done = 0;
   // Fields: sel, bypass, sdr, pad data, term mode, word, expected ts and termination.
   logic [11:0] rows [8] = '{12'h243, 12'h040, 12'h502, 12'h400,
                             12'h87f, 12'h840, 12'hcc3, 12'hc40};
   always #10 clock_in = ~clock_in;
   pad_partner partner (.clock_in(clock_in), .mode_in(pmode), .level_in(level), .pad_out(pad));
   io_cell_input_tristate_regs dut (.clock_in(clock_in), .arst_n_in(arst_n_in),
      .pad_buffer_input_in(pad), .comb_sel_delayed_in(csd), .sdr_sel_delayed_in(ssd),
      .gear_sel_delayed_in(gsd), .tap_from_bus_in(tfb), .tap_config_in(tcfg),
      .calibration_bus_in(cbus), .aligner_enable_in(al_en), .aligner_hold_in(al_hold),
      .window_size_in(win), .gear_x4_in(gx4), .input_clock_enable_in(ce),
      .input_side_local_reset_in(input_side_local_reset), .output_side_local_reset_in(output_side_local_reset),
      .global_set_reset_in(global_set_reset), .gsr_enable_input_in(gen_i), .gsr_enable_tristate_in(gen_t),
      .input_set_mode_in(iset), .tristate_set_mode_in(tset), .lsr_async_in(lasync),
      .second_is_latch_in(latch2), .tristate_bypass_in(tbyp), .tristate_sdr_in(tsdr),
      .tristate_word_in(tword), .tristate_sel_in(tsel), .pad_data_in(pdat),
      .termination_mode_in(term), .comb_input_to_fabric_out(comb),
      .input_clock_to_fabric_out(ick), .registered_input_to_fabric_out(regd),
      .gearbox_word_out(gword), .gearbox_valid_out(gvalid), .delay_tap_out(tap_seen),
      .aligner_locked_out(locked), .pad_tristate_control_out(ts), .termination_on_out(term_on));
   // One comparison; four-state so an unknown never matches.
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("BAD at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   // Lets the pipeline settle, then samples away from the edge.
   task automatic settle(input int n);
      repeat (n) @(posedge clock_in);
      #1;
   endtask
   task automatic end_test(input string name);
      $display("test %s done", name);
   endtask
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   // Expected word of a full gearbox capture when the pad holds high.
   task automatic gear_check(input logic x4, input logic [3:0] exp);
      @(posedge clock_in) gx4 <= x4;
      settle(10);
      repeat (8)
      begin
         if (gvalid === 1'h1)
            break;
         settle(1);
      end
      chk({7'h0, gvalid}, 8'h01);
      chk({4'h0, gword}, {4'h0, exp});
   endtask
   initial
   begin
      settle(3);
      chk({7'h0, ts}, 8'h01);
      chk({comb, ick, regd, gvalid, locked, term_on, 2'h0}, 8'h00);
      repeat (17) @(posedge clock_in);
      arst_n_in <= 1'h1;
      settle(4);
      end_test("reset");
      // Tristate sources and termination, one row at a time.
      foreach (rows[i])
      begin
         @(posedge clock_in)
         {tsel, tbyp, tsdr, pdat, term, tword} <= rows[i][11:2];
         settle(12);
         chk({6'h0, ts, term_on}, {6'h0, rows[i][1:0]});
      end
      end_test("tristate table");
      // Pad held high through plain and delayed paths, with fixed and bus taps.
      @(posedge clock_in)
      begin
         level <= 1'h1;
         tcfg <= 8'h05;
      end
      settle(20);
      chk({6'h0, comb, ick}, 8'h03);
      chk(tap_seen, 8'h05);
      chk({7'h0, regd}, 8'h01);
      @(posedge clock_in)
      begin
         csd <= 1'h1;
         ssd <= 1'h1;
         gsd <= 1'h1;
         tcfg <= 8'hc8;
      end
      // The last tap shows the pad 144 edges late, so wait for the chain to fill.
      settle(160);
      chk(tap_seen, io_cell_pkg::TAP_MAX);
      chk({6'h0, comb, regd}, 8'h03);
      @(posedge clock_in)
      begin
         tfb <= 1'h1;
         cbus <= 8'h07;
      end
      settle(4);
      chk(tap_seen, 8'h07);
      gear_check(1'h0, 4'h3);
      gear_check(1'h1, 4'hf);
      end_test("paths and gearbox");
      // Local reset beats a disabled clock enable, for both levels and both modes.
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clock_in)
         begin
            ce <= 1'h0;
            input_side_local_reset <= 1'h1;
            iset <= m[0];
            lasync <= m[1];
            latch2 <= m[1];
         end
         settle(10);
         chk({7'h0, regd}, {7'h0, m[0]});
      end
      // Global set/reset is ignored while masked and obeyed when enabled.
      @(posedge clock_in)
      begin
         input_side_local_reset <= 1'h0;
         ce <= 1'h1;
         global_set_reset <= 1'h1;
         iset <= 1'h0;
         tsel <= io_cell_pkg::TS_SDR;
         tsdr <= 1'h1;
         output_side_local_reset <= 1'h0;
      end
      settle(10);
      chk({6'h0, regd, ts}, 8'h03);
      @(posedge clock_in)
      begin
         gen_i <= 1'h1;
         gen_t <= 1'h1;
      end
      settle(10);
      chk({6'h0, regd, ts}, 8'h00);
      @(posedge clock_in)
      begin
         global_set_reset <= 1'h0;
         output_side_local_reset <= 1'h1;
         tset <= 1'h1;
         tsdr <= 1'h0;
      end
      settle(10);
      chk({7'h0, ts}, 8'h01);
      end_test("set and reset");
      // Aligner walks on data edges, stays in the chain and freezes on hold.
      @(posedge clock_in)
      begin
         output_side_local_reset <= 1'h0;
         pmode <= 2'h2;
         al_en <= 1'h1;
         tfb <= 1'h0;
         tcfg <= 8'h40;
         win <= 4'h3;
      end
      settle(60);
      chk({7'h0, tap_seen > io_cell_pkg::TAP_MAX}, 8'h00);
      @(posedge clock_in) al_hold <= 1'h1;
      settle(4);
      tap_held = tap_seen;
      settle(30);
      chk(tap_seen, tap_held);
      end_test("aligner");
      print_verdict;
   end
   // Run needs about 520 cycles; give it ample room before calling a hang.
   initial
   begin
      repeat (5000) @(posedge clock_in);
      miscompares++;
      print_verdict;
   end
endmodule
